// >>> design/aop_top.sv
// Audio output port configuration and serial output generator.
// Assumes APB master on sys_clk; mclk and clock fault arrive asynchronously.
//
// Overview of operation
// R1 - Rate field picks 64, 128 or 256 Fs
// R2 - Polarity bit selects data valid edge
// R3 - Every output sample carries 24 bits
// R4 - Host uses 128Fs for six-channel 20-bit
// R5 - Host uses 128Fs for four-channel 24-bit
// R6 - Host uses 256Fs for six-channel 24-bit
// R7 - Host resets when port clocks corrupt
// R8 - Restart and resets clear input FIFO
// R9 - Compressed input resyncs; PCM needs reset
// R10 - Host sends one configuration message
// R11 - Omitted parameters keep default settings
// R12 - External bit clock at least 48Fs
// R13 - Bit and frame clocks derived from mclk
// R14 - Code 8002 ANDs mask, 8001 ORs value
`timescale 1ns/100ps
module aop_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        mclk,
    input  wire logic        clk_fault,
    input  wire logic [23:0] sample_left,
    input  wire logic [23:0] sample_right,
    output logic             sample_req,
    output logic             sclk,
    output logic             lrclk,
    output logic             sdata,
    output logic             fifo_clear
);
    // Bus state
    logic              pready_q, pslverr_q;
    logic [31:0]       prdata_q;
    logic              wr_take, rd_take;
    // Configuration state
    logic [23:0]       cfg_q;
    aop_pkg::aop_state_t state_q;
    logic [1:0]        op_q;
    logic              cfg_hit_q;
    logic              enable_q, pcm_q, corrupt_q, fifo_clear_q;
    logic              softrst, restart;
    // Clock sync
    logic              mclk_s1, mclk_s2, mclk_s3, flt_s1, flt_s2;
    logic              mclk_edge;
    // Serial generator
    logic [2:0]        rate_q;
    logic [1:0]        div_q;
    logic              bclk_q, sclk_q, lrclk_q, sdata_q, req_q;
    logic [7:0]        bit_q;
    logic [23:0]       left_q, right_q;
    logic              fall_edge;

    // Mclk half periods per bit clock half period, less one (terminal count of div_q)
    function automatic logic [1:0] half_div(input logic [2:0] rate);
        unique case (rate)
            aop_pkg::RATE_128: half_div = 2'h1;
            aop_pkg::RATE_256: half_div = 2'h0;
            default:           half_div = 2'h3;
        endcase
    endfunction : half_div

    // Last bit index of a frame
    function automatic logic [7:0] frame_last(input logic [2:0] rate);
        unique case (rate)
            aop_pkg::RATE_128: frame_last = 8'h7F;
            aop_pkg::RATE_256: frame_last = 8'hFF;
            default:           frame_last = 8'h3F;
        endcase
    endfunction : frame_last

    assign wr_take = psel && penable && pready_q && pwrite;
    assign rd_take = psel && penable && !pwrite;
    assign softrst = wr_take && paddr == aop_pkg::ADDR_CTRL && pwdata[aop_pkg::CTRL_SOFTRST];
    assign restart = wr_take && paddr == aop_pkg::ADDR_CTRL && pwdata[aop_pkg::CTRL_RESTART];

    // One wait state, then answer with data and error
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && paddr != aop_pkg::ADDR_MSG
                         && paddr != aop_pkg::ADDR_CTRL && paddr != aop_pkg::ADDR_CFG
                         && paddr != aop_pkg::ADDR_STATUS;
            prdata_q  <= 32'h00000000;
            if (rd_take && !pready_q) begin
                unique case (paddr)
                    aop_pkg::ADDR_CTRL:   prdata_q <= {28'h0000000, pcm_q, enable_q, 2'h0};
                    aop_pkg::ADDR_CFG:    prdata_q <= {8'h00, cfg_q};
                    aop_pkg::ADDR_STATUS: prdata_q <= {30'h00000000,
                                                       state_q == aop_pkg::AOP_OPERAND,
                                                       corrupt_q};
                    default:              prdata_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Message parser: header then operand word
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q   <= aop_pkg::AOP_IDLE;
            op_q      <= 2'h0;
            cfg_hit_q <= 1'b0;
            cfg_q     <= aop_pkg::CFG_RESET;
        end else if (softrst) begin
            state_q   <= aop_pkg::AOP_IDLE;
            cfg_q     <= aop_pkg::CFG_RESET; // R11
        end else if (wr_take && paddr == aop_pkg::ADDR_MSG) begin
            unique case (state_q)
                aop_pkg::AOP_IDLE: begin
                    if (pwdata[23:16] == aop_pkg::MSG_PREFIX
                        && (pwdata[15:8] == aop_pkg::MSG_OP_AND
                        || pwdata[15:8] == aop_pkg::MSG_OP_OR)) begin
                        state_q   <= aop_pkg::AOP_OPERAND;
                        op_q      <= pwdata[9:8];
                        cfg_hit_q <= pwdata[7:0] == aop_pkg::CFG_WORD_ADDR;
                    end
                end
                aop_pkg::AOP_OPERAND: begin
                    state_q <= aop_pkg::AOP_IDLE;
                    if (cfg_hit_q && op_q == aop_pkg::MSG_OP_AND[1:0])
                        cfg_q <= cfg_q & pwdata[23:0]; // R14
                    else if (cfg_hit_q)
                        cfg_q <= cfg_q | pwdata[23:0]; // R14
                end
            endcase
        end
    end

    // Control bits, FIFO clear pulse and corruption flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            enable_q     <= 1'b0;
            pcm_q        <= 1'b0;
            corrupt_q    <= 1'b0;
            fifo_clear_q <= 1'b1;
        end else begin
            fifo_clear_q <= softrst || restart; // R8
            if (wr_take && paddr == aop_pkg::ADDR_CTRL) begin
                enable_q <= pwdata[aop_pkg::CTRL_ENABLE];
                pcm_q    <= pwdata[aop_pkg::CTRL_PCM];
            end
            // Set wins over the clearing reset
            if (flt_s2 && pcm_q)
                corrupt_q <= 1'b1; // R9
            else if (softrst || restart)
                corrupt_q <= 1'b0;
        end
    end

    // Two-stage synchronisers for mclk and fault
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mclk_s1 <= 1'b0;
            mclk_s2 <= 1'b0;
            mclk_s3 <= 1'b0;
            flt_s1  <= 1'b0;
            flt_s2  <= 1'b0;
        end else begin
            mclk_s1 <= mclk;
            mclk_s2 <= mclk_s1;
            mclk_s3 <= mclk_s2;
            flt_s1  <= clk_fault;
            flt_s2  <= flt_s1;
        end
    end

    assign mclk_edge = mclk_s2 != mclk_s3;
    assign fall_edge = mclk_edge && div_q == half_div(rate_q) && bclk_q;

    // Bit clock divider, frame counter and sample latch
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rate_q  <= aop_pkg::RATE_64;
            div_q   <= 2'h0;
            bclk_q  <= 1'b0;
            bit_q   <= 8'h00;
            left_q  <= 24'h000000;
            right_q <= 24'h000000;
            req_q   <= 1'b0;
        end else if (!enable_q) begin
            rate_q  <= cfg_q[aop_pkg::RATE_LSB +: 3];
            div_q   <= 2'h0;
            bclk_q  <= 1'b0;
            bit_q   <= 8'h00;
            req_q   <= 1'b0;
        end else begin
            req_q <= 1'b0;
            if (mclk_edge) begin
                if (div_q == half_div(rate_q)) begin // R13
                    div_q  <= 2'h0;
                    bclk_q <= !bclk_q;
                end else begin
                    div_q <= div_q + 2'h1;
                end
            end
            // Data changes on the internal falling edge
            if (fall_edge) begin
                if (bit_q == frame_last(rate_q)) begin
                    bit_q   <= 8'h00;
                    rate_q  <= cfg_q[aop_pkg::RATE_LSB +: 3]; // R1
                    left_q  <= sample_left; // R3
                    right_q <= sample_right;
                    req_q   <= 1'b1;
                end else begin
                    bit_q <= bit_q + 8'h01;
                end
            end
        end
    end

    // Output pins, polarity applied to the bit clock
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_q  <= 1'b0;
            lrclk_q <= 1'b0;
            sdata_q <= 1'b0;
        end else begin
            sclk_q  <= enable_q && (bclk_q ^ cfg_q[aop_pkg::POL_BIT]); // R2
            lrclk_q <= enable_q && (bit_q <= (frame_last(rate_q) >> 1));
            if (!enable_q)
                sdata_q <= 1'b0;
            else if (bit_q <= (frame_last(rate_q) >> 1))
                sdata_q <= bit_q < 8'(aop_pkg::SAMPLE_BITS)
                           && left_q[5'(aop_pkg::SAMPLE_BITS - 1) - bit_q[4:0]]; // R3
            else
                sdata_q <= (bit_q - (frame_last(rate_q) >> 1) - 8'h01)
                           < 8'(aop_pkg::SAMPLE_BITS)
                           && right_q[5'(aop_pkg::SAMPLE_BITS - 1)
                           - 5'(bit_q - (frame_last(rate_q) >> 1) - 8'h01)];
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign sclk       = sclk_q;
    assign lrclk      = lrclk_q;
    assign sdata      = sdata_q;
    assign sample_req = req_q;
    assign fifo_clear = fifo_clear_q;
endmodule : aop_top

// >>> pkg/aop_pkg.sv
// Constants for the audio output port configuration block.
// Assumes a 200 MHz system clock and a 32-bit APB register bus.
package aop_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_MSG      = 8'h00;
    localparam logic [7:0]  ADDR_CTRL     = 8'h04;
    localparam logic [7:0]  ADDR_CFG      = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    // Control bits
    localparam int          CTRL_RESTART  = 0;
    localparam int          CTRL_SOFTRST  = 1;
    localparam int          CTRL_ENABLE   = 2;
    localparam int          CTRL_PCM      = 3;
    // Message word layout
    localparam logic [7:0]  MSG_PREFIX    = 8'h80;
    localparam logic [7:0]  MSG_OP_AND    = 8'h02;
    localparam logic [7:0]  MSG_OP_OR     = 8'h01;
    localparam logic [7:0]  CFG_WORD_ADDR = 8'h7F;
    // Output configuration word fields
    localparam int          RATE_LSB      = 8;
    localparam int          POL_BIT       = 19;
    localparam logic [2:0]  RATE_64       = 3'h1;
    localparam logic [2:0]  RATE_128      = 3'h2;
    localparam logic [2:0]  RATE_256      = 3'h3;
    localparam logic [23:0] CFG_RESET     = 24'h000100;
    // Sample format
    localparam int          SAMPLE_BITS   = 24;
    // Parser states
    typedef enum logic {AOP_IDLE, AOP_OPERAND} aop_state_t;
endpackage : aop_pkg

// >>> testbench/aop_checker.sv
// Checker for bus answers and output pulses of the audio port block.
// Bound to aop_top; sees its ports only.
`timescale 1ns/100ps
module aop_checker (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        sample_req,
    input wire logic        fifo_clear
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic acc;
    logic mapped;
    // Access phase still waiting for its answer
    assign acc = psel && penable && !pready;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C};
    property p_ans; acc |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("access not answered");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_idle; !pready |-> prdata == 32'h0; endproperty
    a_idle: assert property (p_idle) else $error("read data outside answer");
    property p_unmap; acc && !mapped |=> pslverr; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    property p_map; acc && mapped |=> !pslverr; endproperty
    a_map: assert property (p_map) else $error("mapped refused");
    property p_clr; acc && pwrite && paddr == 8'h04 && pwdata[1:0] != 2'h0
        |=> ##[0:2] fifo_clear; endproperty
    a_clr: assert property (p_clr) else $error("no clear");
    property p_req; sample_req |=> !sample_req; endproperty
    a_req: assert property (p_req) else $error("request too long");
    c_msg: cover property (acc && pwrite && paddr == 8'h00);
    c_err: cover property (pslverr);
    c_req: cover property (sample_req);
endmodule : aop_checker
bind aop_top aop_checker i_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sample_req, .fifo_clear);

// >>> testbench/aop_dac_model.sv
// Receiver model for the serial audio output port.
// Captures on the valid bit clock edge chosen by pol.
`timescale 1ns/100ps
module aop_dac_model (
    input  wire logic        sclk,
    input  wire logic        lrclk,
    input  wire logic        sdata,
    input  wire logic        pol,
    output logic      [23:0] left_word,
    output int               half_bits,
    output logic             tail_ok
);
    logic [23:0] sh;
    logic        lr_q;
    logic        ones;
    int          cnt;
    initial begin
        {sh, lr_q, ones, left_word, tail_ok} = '0;
        cnt = 0;
        half_bits = 0;
    end
    // Rising edge valid for pol 0, falling for pol 1
    always @(sclk) begin
        if (sclk !== pol) begin
            if (lrclk !== lr_q) begin
                half_bits = cnt;
                tail_ok = !ones;
                if (lr_q) left_word = sh;
                cnt = 0;
                ones = 1'b0;
                lr_q = lrclk;
            end
            if (cnt < 24) sh = {sh[22:0], sdata};
            else if (sdata) ones = 1'b1;
            cnt++;
        end
    end
endmodule : aop_dac_model

// >>> testbench/tb.sv
// Testbench for the audio output port configuration block.
// Drives APB and master clock; a receiver model sits on the port.
`timescale 1ns/100ps
module tb;
    logic        sys_clk, rst, psel, penable, pwrite, mclk, clk_fault, pol, err, fc_seen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sample_req, sclk, lrclk, sdata, fifo_clear, tail_ok;
    logic [23:0] left_word;
    int          half_bits, error_cnt, n_checks, cyc, req_n;
    localparam logic [23:0] SL = 24'hA5C3F1;
    aop_top i_dut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .mclk, .clk_fault, .sample_left(SL), .sample_right(~SL),
        .sample_req, .sclk, .lrclk, .sdata, .fifo_clear);
    aop_dac_model i_dac (.sclk, .lrclk, .sdata, .pol, .left_word, .half_bits, .tail_ok);
    // System and master clocks
    initial begin sys_clk = 0; forever #2.5 sys_clk = ~sys_clk; end
    initial begin mclk = 0; #7; forever #32 mclk = ~mclk; end
    // Timeout and clear tracker
    always @(posedge sys_clk) begin
        cyc++;
        if (fifo_clear) fc_seen <= 1'b1;
        if (sample_req) req_n++;
        if (cyc == 80000) begin error_cnt++; complete_run; end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin error_cnt++; $display("BAD %s exp %h seen %h", nm, e, s); end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
        chk("pready", {31'h0, pready}, 32'h1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge sys_clk);
    endtask : apb
    task automatic msg(input logic [23:0] h, input logic [23:0] v);
        apb(1'b1, 8'h00, {8'h00, h});
        apb(1'b1, 8'h00, {8'h00, v});
    endtask : msg
    // One sample request per frame between the first and third frame edge
    task automatic frames;
        @(negedge lrclk);
        req_n = 0;
        repeat (2) @(negedge lrclk);
        @(posedge sys_clk);
        chk("req", req_n, 32'd2);
    endtask : frames
    // Defaults, then a mask aimed at another word
    task automatic t_defaults;
        chk("clear", {31'h0, fifo_clear}, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", rd, 32'h00000100);
        msg(24'h80027E, 24'h000000);
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", rd, 32'h00000100);
    endtask : t_defaults
    // Each rate code, frame length and sample bits
    task automatic t_rates;
        apb(1'b1, 8'h04, 32'h4);
        for (int i = 0; i < 3; i++) begin
            msg(24'h80027F, 24'hFFF8FF);
            msg(24'h80017F, {13'h0, 3'(i + 1), 8'h00});
            apb(1'b0, 8'h08, 32'h0);
            chk("cfg", rd, {21'h0, 3'(i + 1), 8'h00});
            frames;
            chk("half", half_bits, 32 << i);
            chk("left", {8'h0, left_word}, {8'h0, SL});
            chk("tail", {31'h0, tail_ok}, 32'h1);
        end
    endtask : t_rates
    // Inverted polarity
    task automatic t_pol;
        msg(24'h80017F, 24'h080000);
        pol <= 1'b1;
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", rd, 32'h00080300);
        frames;
        chk("left", {8'h0, left_word}, {8'h0, SL});
        chk("half", half_bits, 32'd128);
    endtask : t_pol
    // Unmapped access refused, message reads zero
    task automatic t_refuse;
        apb(1'b1, 8'h40, 32'hFFFFFFFF);
        chk("err", {31'h0, err}, 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk("rd", rd, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk("msg", rd, 32'h0);
    endtask : t_refuse
    // Corruption flag, restart and soft reset
    task automatic t_resets;
        clk_fault <= 1'b1;
        apb(1'b1, 8'h04, 32'hC);
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("flag", rd, 32'h1);
        {clk_fault, fc_seen} <= 2'b00;
        repeat (4) @(posedge sys_clk);
        apb(1'b1, 8'h04, 32'hD);
        apb(1'b0, 8'h0C, 32'h0);
        chk("flag", rd, 32'h0);
        chk("clr", {31'h0, fc_seen}, 32'h1);
        // Leave PCM mode before the fault rises, else the sync sets the flag
        apb(1'b1, 8'h04, 32'h4);
        clk_fault <= 1'b1;
        repeat (4) @(posedge sys_clk);
        apb(1'b0, 8'h0C, 32'h0);
        chk("flag", rd, 32'h0);
        {clk_fault, fc_seen} <= 2'b00;
        apb(1'b1, 8'h04, 32'h6);
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", rd, 32'h00000100);
        chk("clr", {31'h0, fc_seen}, 32'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk("ctrl", rd, 32'h4);
    endtask : t_resets
    initial begin
        {rst, psel, penable, pwrite, paddr, pwdata, clk_fault, pol, fc_seen} = '0;
        rst = 1'b1;
        {error_cnt, n_checks, cyc} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_defaults;
        t_rates;
        t_pol;
        t_refuse;
        t_resets;
        complete_run;
    end
endmodule : tb
